// file: src/interp_speed_regs.vh
`ifndef INTERP_SPEED_REGS_VH
`define INTERP_SPEED_REGS_VH
`define UNIT_MM 2'h0
`define UNIT_INCH 2'h1
`define UNIT_DEG 2'h2
`define UNIT_PLS 2'h3
`define MODE_COMBINED 2'h0
`define MODE_LONG 2'h1
`define MODE_REF 2'h2
`define SPACE_DATA 2'h0
`define SPACE_LINK 2'h1
`define SPACE_MOTION 2'h2
`define DATA_ADDR_MIN 13'h0320
`define DATA_ADDR_MAX 13'h1FFF
`define LINK_ADDR_MAX 13'h1FFF
`define MOTION_ADDR_MAX 13'h1F3F
`define MEM_DEPTH 24576
`define ERR_NONE 16'h0000
`define ERR_SPEED 16'h0004
`define ERR_INDIRECT 16'h0080
`define ERR_REF_AXIS 16'h0081
`define INCH_TO_MM_MUL 8'hFE
`define INCH_TO_MM_DIV 8'h0A
`define DEG_X10_MUL 4'hA
`define SEC_PER_MIN 6'h3C
`define ITEM_SPEED 3'h4
`define ITEM_REF 3'h5
`define ITEM_LAST 3'h6
`define SQRT_TOP 6'h28
`define DIV_STEPS 7'h50
`endif

// file: src/speed_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "interp_speed_regs.vh"
module speed_divider (
  input wire i_clock,
  input wire i_arst_n,
  input wire i_start,
  input wire [79:0] i_dividend,
  input wire [40:0] i_divisor,
  output reg o_done_ff,
  output reg [79:0] o_quotient_ff
);
  reg [41:0] rem_ff;
  reg [79:0] quo_ff;
  reg [40:0] dsr_ff;
  reg [6:0] cnt_ff;
  reg busy_ff;
  reg [41:0] shifted;
  reg take;

  always @* begin
    shifted = {rem_ff[40:0], quo_ff[79]};
    take = (shifted >= {1'b0, dsr_ff});
  end

  // Restoring division, one quotient bit per clock
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rem_ff <= 42'h0;
      quo_ff <= 80'h0;
      dsr_ff <= 41'h0;
      cnt_ff <= 7'h0;
      busy_ff <= 1'b0;
      o_done_ff <= 1'b0;
      o_quotient_ff <= 80'h0;
    end else begin
      o_done_ff <= 1'b0;
      if (i_start) begin
        rem_ff <= 42'h0;
        quo_ff <= i_dividend;
        dsr_ff <= i_divisor;
        cnt_ff <= `DIV_STEPS;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        rem_ff <= take ? (shifted - {1'b0, dsr_ff}) : shifted;
        quo_ff <= {quo_ff[78:0], take};
        cnt_ff <= cnt_ff - 7'h1;
        if (cnt_ff == 7'h1) begin
          busy_ff <= 1'b0;
          o_done_ff <= 1'b1;
          o_quotient_ff <= {quo_ff[78:0], take};
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: src/interpolation_speed_calculator.v
`timescale 1ns/1ps
`default_nettype none
`include "interp_speed_regs.vh"
module interpolation_speed_calculator (
  input wire i_clock,
  input wire i_arst_n,
  input wire i_wr_en,
  input wire [1:0] i_wr_space,
  input wire [12:0] i_wr_addr,
  input wire [31:0] i_wr_data,
  input wire i_start,
  input wire [2:0] i_axis_count,
  input wire [19:0] i_axis_id,
  input wire [7:0] i_axis_unit,
  input wire [63:0] i_gear_num,
  input wire [63:0] i_gear_den,
  input wire [1:0] i_interp_unit,
  input wire [1:0] i_speed_mode,
  input wire i_degree_x10,
  input wire [35:0] i_speed_limit,
  input wire [5:0] i_item_indirect,
  input wire [11:0] i_item_space,
  input wire [77:0] i_item_addr,
  input wire [127:0] i_travel_const,
  input wire [31:0] i_speed_const,
  input wire [2:0] i_ref_axis_const,
  input wire [31:0] i_axis_done,
  output reg [31:0] o_axis_start_accept_flags_ff,
  output reg o_busy_ff,
  output reg o_done_ff,
  output reg o_rejected_ff,
  output reg [15:0] o_error_item_ff,
  output reg [159:0] o_axis_speed_ff,
  output reg [159:0] o_axis_travel_ff,
  output reg [3:0] o_axis_dir_ff,
  output reg [35:0] o_ramp_speed_ff,
  output reg [1:0] o_long_axis_ff
);
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_FETCH = 4'h1;
  localparam [3:0] S_RESOLVE = 4'h2;
  localparam [3:0] S_SQSUM = 4'h3;
  localparam [3:0] S_SQRT = 4'h4;
  localparam [3:0] S_DIV = 4'h5;
  localparam [3:0] S_DIVWAIT = 4'h6;
  localparam [3:0] S_DONE = 4'h7;

  reg [3:0] state_ff;
  reg [31:0] mem [0:`MEM_DEPTH-1];
  reg [31:0] rd_data_ff;
  reg [31:0] raw_ff [0:5];
  reg [39:0] trv_ff [0:3];
  reg [35:0] spd_ff;
  reg [1:0] ref_ff;
  reg [1:0] long_ff;
  reg [1:0] mode_ff;
  reg [2:0] cnt_ff;
  reg [2:0] k_ff;
  reg [2:0] slot_ff;
  reg [81:0] sum_ff;
  reg [40:0] root_ff;
  reg [5:0] bit_ff;
  reg div_start_ff;
  reg [79:0] div_num_ff;
  reg [40:0] div_den_ff;
  wire div_done;
  wire [79:0] div_quo;
  wire [14:0] wr_idx;
  reg [14:0] rd_idx;
  reg [2:0] item;
  reg [31:0] fetch_word;
  reg addr_good;
  reg single;
  reg mism;
  reg found;
  reg [1:0] gslot;
  reg [1:0] u;
  reg [1:0] eu;
  reg [31:0] rw;
  reg [39:0] mag;
  reg [39:0] nxt_trv [0:3];
  reg [3:0] nxt_neg;
  reg [35:0] s;
  reg [39:0] p;
  reg [35:0] nxt_spd;
  reg nxt_over;
  reg nxt_zero;
  reg nxt_ref_bad;
  reg [1:0] nxt_ref;
  reg [1:0] nxt_long;
  reg [15:0] nxt_err;
  reg nxt_fail;
  reg [31:0] nxt_set;
  reg [81:0] nxt_sum;
  reg [40:0] trial;
  reg [81:0] trial_sq;
  reg [40:0] den;
  integer i;
  // Each process owns its loop index so no always @* wakes on another's loop
  integer ig;
  integer iq;
  integer ir;

  function addr_ok;
    input [1:0] sp;
    input [12:0] ad;
    begin
      case (sp)
        `SPACE_DATA: addr_ok = (ad >= `DATA_ADDR_MIN) && (ad <= `DATA_ADDR_MAX);
        `SPACE_LINK: addr_ok = (ad <= `LINK_ADDR_MAX);
        `SPACE_MOTION: addr_ok = (ad <= `MOTION_ADDR_MAX);
        default: addr_ok = 1'b0;
      endcase
    end
  endfunction

  function [39:0] to_pulse;
    input [39:0] v;
    input [15:0] num;
    input [15:0] dv;
    reg [55:0] t;
    begin
      t = ({16'h0000, v} * {40'h0, num}) / {40'h0, dv};
      to_pulse = (dv == 16'h0000) ? v : t[39:0];
    end
  endfunction

  function [39:0] inch_conv;
    input [39:0] v;
    input to_mm;
    reg [47:0] t;
    begin
      if (to_mm) begin
        t = ({8'h00, v} * `INCH_TO_MM_MUL) / `INCH_TO_MM_DIV;
      end else begin
        t = ({8'h00, v} * `INCH_TO_MM_DIV) / `INCH_TO_MM_MUL;
      end
      inch_conv = t[39:0];
    end
  endfunction

  assign wr_idx = {i_wr_space, i_wr_addr};

  // Word memory written by the host; illegal spaces and addresses are dropped
  always @(posedge i_clock) begin
    if (i_wr_en && addr_ok(i_wr_space, i_wr_addr)) begin
      mem[wr_idx] <= i_wr_data;
    end
    rd_data_ff <= mem[rd_idx];
  end

  always @* begin
    rd_idx = 15'h0000;
    if (k_ff < `ITEM_LAST) begin
      if (addr_ok(i_item_space[2*k_ff +: 2], i_item_addr[13*k_ff +: 13])) begin
        rd_idx = {i_item_space[2*k_ff +: 2], i_item_addr[13*k_ff +: 13]};
      end
    end
    item = k_ff - 3'h1;
    if (i_item_indirect[item]) begin
      fetch_word = rd_data_ff;
    end else if (item < `ITEM_SPEED) begin
      fetch_word = i_travel_const[32*item +: 32];
    end else if (item == `ITEM_SPEED) begin
      fetch_word = i_speed_const;
    end else begin
      fetch_word = {29'h0, i_ref_axis_const};
    end
  end

  // Every indirect item that the program uses must name a legal word
  always @* begin
    addr_good = 1'b1;
    for (ig = 0; ig < 6; ig = ig + 1) begin
      if (i_item_indirect[ig] && ((ig < i_axis_count) || (ig == 4) ||
          ((ig == 5) && (i_speed_mode == `MODE_REF)))) begin
        if (!addr_ok(i_item_space[2*ig +: 2], i_item_addr[13*ig +: 13])) begin
          addr_good = 1'b0;
        end
      end
    end
  end

  // Resolution of travels, speed, reference and long axis
  always @* begin
    single = (i_axis_count == 3'h1);
    gslot = 2'h0;
    found = 1'b0;
    mism = 1'b0;
    nxt_set = 32'h0;
    for (i = 0; i < 4; i = i + 1) begin
      u = i_axis_unit[2*i +: 2];
      if (i < i_axis_count) begin
        nxt_set[i_axis_id[5*i +: 5]] = 1'b1;
        if ((u == i_interp_unit) && !found) begin
          gslot = i[1:0];
          found = 1'b1;
        end
        if (!single && (u != i_interp_unit) && (u[1] || i_interp_unit[1])) begin
          mism = 1'b1;
        end
      end
    end
    for (i = 0; i < 4; i = i + 1) begin
      u = i_axis_unit[2*i +: 2];
      rw = raw_ff[i];
      mag = rw[31] ? {8'h00, ~rw + 32'h1} : {8'h00, rw};
      nxt_neg[i] = rw[31] && (i < i_axis_count);
      if (i >= i_axis_count) begin
        nxt_trv[i] = 40'h0;
      end else if (single || (u == i_interp_unit)) begin
        nxt_trv[i] = mag;
      end else if (!u[1] && !i_interp_unit[1]) begin
        nxt_trv[i] = inch_conv(mag, i_interp_unit == `UNIT_MM);
      end else begin
        nxt_trv[i] = to_pulse(mag, i_gear_num[16*i +: 16], i_gear_den[16*i +: 16]);
      end
    end
    rw = raw_ff[`ITEM_SPEED];
    nxt_zero = (rw == 32'h0) || rw[31];
    eu = single ? i_axis_unit[1:0] : i_interp_unit;
    s = {4'h0, rw};
    if ((eu == `UNIT_DEG) && i_degree_x10) begin
      s = {4'h0, rw} * `DEG_X10_MUL;
    end
    p = 40'h0;
    if (mism) begin
      p = to_pulse({4'h0, s}, i_gear_num[16*gslot +: 16], i_gear_den[16*gslot +: 16]);
      p = p / `SEC_PER_MIN;
      s = p[35:0];
    end
    nxt_over = (s > i_speed_limit);
    nxt_spd = nxt_over ? i_speed_limit : s;
    rw = raw_ff[`ITEM_REF];
    nxt_ref = rw[1:0] - 2'h1;
    nxt_ref_bad = !single && (i_speed_mode == `MODE_REF) &&
                  ((rw == 32'h0) || (rw > {29'h0, i_axis_count}));
    nxt_long = 2'h0;
    for (i = 1; i < 4; i = i + 1) begin
      if (nxt_trv[i] > nxt_trv[nxt_long]) begin
        nxt_long = i[1:0];
      end
    end
    if (nxt_ref_bad) begin
      nxt_err = `ERR_REF_AXIS;
    end else if (nxt_zero || nxt_over) begin
      nxt_err = `ERR_SPEED;
    end else begin
      nxt_err = `ERR_NONE;
    end
    nxt_fail = nxt_ref_bad || nxt_zero;
  end

  always @* begin
    nxt_sum = 82'h0;
    for (iq = 0; iq < 4; iq = iq + 1) begin
      nxt_sum = nxt_sum + ({42'h0, trv_ff[iq]} * {42'h0, trv_ff[iq]});
    end
    trial = root_ff | ({40'h0, 1'b1} << bit_ff);
    trial_sq = {41'h0, trial} * {41'h0, trial};
    case (mode_ff)
      `MODE_LONG: den = {1'b0, trv_ff[long_ff]};
      `MODE_REF: den = {1'b0, trv_ff[ref_ff]};
      default: den = root_ff;
    endcase
  end

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= S_IDLE;
      for (ir = 0; ir < 6; ir = ir + 1) begin
        raw_ff[ir] <= 32'h0;
      end
      for (ir = 0; ir < 4; ir = ir + 1) begin
        trv_ff[ir] <= 40'h0;
      end
      spd_ff <= 36'h0;
      ref_ff <= 2'h0;
      long_ff <= 2'h0;
      mode_ff <= `MODE_COMBINED;
      cnt_ff <= 3'h0;
      k_ff <= 3'h0;
      slot_ff <= 3'h0;
      sum_ff <= 82'h0;
      root_ff <= 41'h0;
      bit_ff <= 6'h0;
      div_start_ff <= 1'b0;
      div_num_ff <= 80'h0;
      div_den_ff <= 41'h0;
      o_axis_start_accept_flags_ff <= 32'h0;
      o_busy_ff <= 1'b0;
      o_done_ff <= 1'b0;
      o_rejected_ff <= 1'b0;
      o_error_item_ff <= `ERR_NONE;
      o_axis_speed_ff <= 160'h0;
      o_axis_travel_ff <= 160'h0;
      o_axis_dir_ff <= 4'h0;
      o_ramp_speed_ff <= 36'h0;
      o_long_axis_ff <= 2'h0;
    end else begin
      o_done_ff <= 1'b0;
      o_rejected_ff <= 1'b0;
      div_start_ff <= 1'b0;
      // A new accept wins over a done in the same cycle
      if ((state_ff == S_RESOLVE) && !nxt_fail) begin
        o_axis_start_accept_flags_ff <= (o_axis_start_accept_flags_ff & ~i_axis_done) |
                                        nxt_set;
      end else begin
        o_axis_start_accept_flags_ff <= o_axis_start_accept_flags_ff & ~i_axis_done;
      end
      case (state_ff)
        S_IDLE: begin
          if (i_start) begin
            if (addr_good) begin
              state_ff <= S_FETCH;
              k_ff <= 3'h0;
              o_busy_ff <= 1'b1;
            end else begin
              o_rejected_ff <= 1'b1;
              o_error_item_ff <= `ERR_INDIRECT;
            end
          end
        end
        S_FETCH: begin
          // One item per cycle, after a first fetch cycle that only waits for the memory read
          if (k_ff != 3'h0) begin
            raw_ff[item] <= fetch_word;
          end
          k_ff <= k_ff + 3'h1;
          if (k_ff == `ITEM_LAST) begin
            state_ff <= S_RESOLVE;
          end
        end
        S_RESOLVE: begin
          if (nxt_err != `ERR_NONE) begin
            o_error_item_ff <= nxt_err;
          end
          if (nxt_fail) begin
            o_rejected_ff <= 1'b1;
            o_busy_ff <= 1'b0;
            state_ff <= S_IDLE;
          end else begin
            for (ir = 0; ir < 4; ir = ir + 1) begin
              trv_ff[ir] <= nxt_trv[ir];
              o_axis_travel_ff[40*ir +: 40] <= nxt_trv[ir];
            end
            o_axis_speed_ff <= 160'h0;
            o_axis_dir_ff <= nxt_neg;
            spd_ff <= nxt_spd;
            ref_ff <= nxt_ref;
            long_ff <= nxt_long;
            o_long_axis_ff <= nxt_long;
            mode_ff <= i_speed_mode;
            cnt_ff <= i_axis_count;
            o_ramp_speed_ff <= nxt_spd;
            slot_ff <= 3'h0;
            if (single) begin
              o_axis_speed_ff[39:0] <= {4'h0, nxt_spd};
              state_ff <= S_DONE;
            end else if (i_speed_mode == `MODE_COMBINED) begin
              state_ff <= S_SQSUM;
            end else begin
              state_ff <= S_DIV;
            end
          end
        end
        S_SQSUM: begin
          sum_ff <= nxt_sum;
          root_ff <= 41'h0;
          bit_ff <= `SQRT_TOP;
          state_ff <= S_SQRT;
        end
        S_SQRT: begin
          // Bitwise integer square root, top bit first
          if (trial_sq <= sum_ff) begin
            root_ff <= trial;
          end
          bit_ff <= bit_ff - 6'h1;
          if (bit_ff == 6'h0) begin
            state_ff <= S_DIV;
          end
        end
        S_DIV: begin
          if (slot_ff >= cnt_ff) begin
            state_ff <= S_DONE;
          end else if (den == 41'h0) begin
            slot_ff <= slot_ff + 3'h1;
          end else begin
            div_num_ff <= {44'h0, spd_ff} * {40'h0, trv_ff[slot_ff[1:0]]};
            div_den_ff <= den;
            div_start_ff <= 1'b1;
            state_ff <= S_DIVWAIT;
          end
        end
        S_DIVWAIT: begin
          if (div_done) begin
            // Saturate when a short reference travel scales a speed too far
            if (|div_quo[79:40]) begin
              o_axis_speed_ff[40*slot_ff +: 40] <= {40{1'b1}};
            end else begin
              o_axis_speed_ff[40*slot_ff +: 40] <= div_quo[39:0];
            end
            slot_ff <= slot_ff + 3'h1;
            state_ff <= S_DIV;
          end
        end
        S_DONE: begin
          o_done_ff <= 1'b1;
          o_busy_ff <= 1'b0;
          state_ff <= S_IDLE;
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  speed_divider u_divider (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_start(div_start_ff),
    .i_dividend(div_num_ff),
    .i_divisor(div_den_ff),
    .o_done_ff(div_done),
    .o_quotient_ff(div_quo)
  );
endmodule
`default_nettype wire

// file: tb/interp_speed_chk.sv
`timescale 1ns/1ps
`default_nettype none
module interp_speed_chk (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire logic [2:0] i_axis_count,
  input wire logic [19:0] i_axis_id,
  input wire logic [7:0] i_axis_unit,
  input wire logic [1:0] i_interp_unit,
  input wire logic [1:0] i_speed_mode,
  input wire logic [35:0] i_speed_limit,
  input wire logic [5:0] i_item_indirect,
  input wire logic [11:0] i_item_space,
  input wire logic [31:0] i_speed_const,
  input wire logic [2:0] i_ref_axis_const,
  input wire logic [31:0] o_axis_start_accept_flags_ff,
  input wire logic o_busy_ff,
  input wire logic o_done_ff,
  input wire logic o_rejected_ff,
  input wire logic [15:0] o_error_item_ff,
  input wire logic [159:0] o_axis_speed_ff,
  input wire logic [159:0] o_axis_travel_ff,
  input wire logic [35:0] o_ramp_speed_ff,
  input wire logic [1:0] o_long_axis_ff
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  wire mm1 = o_done_ff && i_axis_count == 3'h1 && i_axis_unit[1:0] == 2'h0;
  wire mm_all = o_done_ff && i_axis_unit == 8'h00 && i_interp_unit == 2'h0 && i_axis_count > 3'h1;
  wire over = i_speed_const > i_speed_limit;
  wire [35:0] clamp = over ? i_speed_limit : {4'h0, i_speed_const};
  sequence s_go;
    i_start && !o_busy_ff && i_item_indirect == 6'h00 && i_axis_count == 3'h1 &&
      i_speed_const != 32'h0 && !i_speed_const[31];
  endsequence
  sequence s_accept;
    ##[8:9] o_axis_start_accept_flags_ff[i_axis_id[4:0]] ##1 o_done_ff;
  endsequence
  property p_start;
    s_go |-> s_accept;
  endproperty
  property p_reject;
    i_start && !o_busy_ff && i_item_indirect[4] && i_item_space[9:8] == 2'h3 |->
      ##[1:2] o_rejected_ff && o_error_item_ff == 16'h0080;
  endproperty
  property p_travel;
    $changed(o_axis_travel_ff) |-> $past(o_busy_ff);
  endproperty
  property p_done;
    o_done_ff |-> !o_busy_ff ##1 !o_done_ff;
  endproperty
  property p_err;
    $changed(o_error_item_ff) |-> o_error_item_ff inside {16'h0004, 16'h0080, 16'h0081};
  endproperty
  property p_clamp;
    mm1 && !i_item_indirect[4] |-> o_ramp_speed_ff == clamp &&
      (!over || o_error_item_ff == 16'h0004);
  endproperty
  property p_single;
    mm1 |-> o_axis_speed_ff[39:0] == {4'h0, o_ramp_speed_ff};
  endproperty
  property p_long;
    mm_all && i_speed_mode == 2'h1 |->
      o_axis_speed_ff[o_long_axis_ff * 40 +: 40] == {4'h0, o_ramp_speed_ff} &&
      o_axis_travel_ff[o_long_axis_ff * 40 +: 40] >= o_axis_travel_ff[39:0];
  endproperty
  property p_ref;
    mm_all && i_speed_mode == 2'h2 && !i_item_indirect[5] |->
      o_axis_speed_ff[(i_ref_axis_const - 3'h1) * 40 +: 40] == {4'h0, o_ramp_speed_ff};
  endproperty
  a_start: assert property (p_start) else $error("start not accepted in time");
  a_reject: assert property (p_reject) else $error("bad space not refused");
  a_travel: assert property (p_travel) else $error("snapshot moved while idle");
  a_done: assert property (p_done) else $error("done pulse malformed");
  a_err: assert property (p_err) else $error("unknown error code stored");
  a_clamp: assert property (p_clamp) else $error("speed clamp wrong");
  a_single: assert property (p_single) else $error("single axis speed wrong");
  a_long: assert property (p_long) else $error("long axis speed wrong");
  a_ref: assert property (p_ref) else $error("reference axis speed wrong");
endmodule
bind interpolation_speed_calculator interp_speed_chk u_chk (
  .i_clock(i_clock), .i_arst_n(i_arst_n), .i_start(i_start), .i_axis_count(i_axis_count),
  .i_axis_id(i_axis_id), .i_axis_unit(i_axis_unit), .i_interp_unit(i_interp_unit),
  .i_speed_mode(i_speed_mode), .i_speed_limit(i_speed_limit),
  .i_item_indirect(i_item_indirect), .i_item_space(i_item_space),
  .i_speed_const(i_speed_const), .i_ref_axis_const(i_ref_axis_const),
  .o_axis_start_accept_flags_ff(o_axis_start_accept_flags_ff), .o_busy_ff(o_busy_ff),
  .o_done_ff(o_done_ff), .o_rejected_ff(o_rejected_ff), .o_error_item_ff(o_error_item_ff),
  .o_axis_speed_ff(o_axis_speed_ff), .o_axis_travel_ff(o_axis_travel_ff),
  .o_ramp_speed_ff(o_ramp_speed_ff), .o_long_axis_ff(o_long_axis_ff));
`default_nettype wire

// file: tb/interp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module interp_host_model (
  input wire logic i_clock,
  input wire logic [31:0] i_flags,
  input wire logic i_rejected,
  output logic o_wr_en,
  output logic [1:0] o_wr_space,
  output logic [12:0] o_wr_addr,
  output logic [31:0] o_wr_data,
  output logic o_start
);
  initial begin
    o_wr_en = 1'b0;
    o_wr_space = 2'h0;
    o_wr_addr = 13'h0000;
    o_wr_data = 32'h0;
    o_start = 1'b0;
  end
  // Data lines flip once the strobe drops so stale values are never reused
  task automatic put(input logic [1:0] sp, input logic [12:0] ad, input logic [31:0] d);
    @(posedge i_clock);
    #1;
    o_wr_en = 1'b1;
    o_wr_space = sp;
    o_wr_addr = ad;
    o_wr_data = d;
    @(posedge i_clock);
    #1;
    o_wr_en = 1'b0;
    o_wr_data = ~d;
  endtask
  // Words are all written before the start and left alone until the flag shows
  task automatic go(input logic [4:0] id, output logic rej);
    @(posedge i_clock);
    #1;
    o_start = 1'b1;
    @(posedge i_clock);
    #1;
    o_start = 1'b0;
    rej = i_rejected;
    for (int k = 0; k < 40 && !i_flags[id] && !rej; k++) begin
      @(posedge i_clock);
      #1;
      rej = i_rejected;
    end
  endtask
endmodule
`default_nettype wire

// file: tb/interpolation_speed_calculator_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module interpolation_speed_calculator_tb;
  logic clk, rst_n, x10, wr_en, start, busy, done, rej, r;
  logic [1:0] wr_sp, iunit, mode, lax;
  logic [12:0] wr_ad;
  logic [31:0] wr_d, spd, adone, flags;
  logic [2:0] cnt, refc;
  logic [19:0] ids;
  logic [7:0] unit;
  logic [35:0] lim, ramp;
  logic [5:0] ind;
  logic [11:0] isp;
  logic [77:0] iad;
  logic [127:0] trv;
  logic [63:0] gnum, gden;
  logic [159:0] spdo, trvo;
  logic [15:0] err, prev;
  logic [3:0] dir;
  int n_mismatch = 0;
  int num_checks = 0;
  interp_host_model u_host (.i_clock(clk), .i_flags(flags), .i_rejected(rej),
    .o_wr_en(wr_en), .o_wr_space(wr_sp), .o_wr_addr(wr_ad), .o_wr_data(wr_d), .o_start(start));
  interpolation_speed_calculator DUT (.i_clock(clk), .i_arst_n(rst_n), .i_wr_en(wr_en),
    .i_wr_space(wr_sp), .i_wr_addr(wr_ad), .i_wr_data(wr_d), .i_start(start),
    .i_axis_count(cnt), .i_axis_id(ids), .i_axis_unit(unit), .i_gear_num(gnum),
    .i_gear_den(gden), .i_interp_unit(iunit), .i_speed_mode(mode), .i_degree_x10(x10),
    .i_speed_limit(lim), .i_item_indirect(ind), .i_item_space(isp), .i_item_addr(iad),
    .i_travel_const(trv), .i_speed_const(spd), .i_ref_axis_const(refc), .i_axis_done(adone),
    .o_axis_start_accept_flags_ff(flags), .o_busy_ff(busy), .o_done_ff(done),
    .o_rejected_ff(rej), .o_error_item_ff(err), .o_axis_speed_ff(spdo),
    .o_axis_travel_ff(trvo), .o_axis_dir_ff(dir), .o_ramp_speed_ff(ramp),
    .o_long_axis_ff(lax));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic setp(input logic [2:0] n, input logic [1:0] m, input logic [7:0] u,
      input logic [31:0] s, input logic [31:0] t0, input logic [31:0] t1);
    cnt = n;
    mode = m;
    unit = u;
    spd = s;
    trv = {64'h0, t1, t0};
  endtask
  task automatic run;
    u_host.go(ids[4:0], r);
    `CHK("flag", ~r, flags[ids[4:0]])
    for (int k = 0; k < 600 && !r && !done; k++) begin
      @(posedge clk);
      #1;
    end
    `CHK("finish", 1'b1, done | r)
    adone = 32'hFFFFFFFF;
    @(posedge clk);
    #1;
    adone = 32'h0;
  endtask
  task automatic t_single;
    lim = 36'h3E8;
    setp(3'h1, 2'h0, 8'h00, 32'h1F4, 32'h3E8, 32'h0);
    run;
    `CHK("speed", 40'h1F4, spdo[39:0])
    `CHK("error", 16'h0000, err)
    lim = 36'h5DC;
    spd = 32'h7D0;
    run;
    `CHK("clamp", 40'h5DC, spdo[39:0])
    `CHK("error", 16'h0004, err)
    ind = 6'h01;
    iad[12:0] = 13'h0320;
    u_host.put(2'h0, 13'h0320, 32'h4D2);
    run;
    u_host.put(2'h0, 13'h0320, 32'h309);
    `CHK("snapshot", 40'h4D2, trvo[39:0])
    run;
    `CHK("resample", 40'h309, trvo[39:0])
    ind = 6'h00;
    $display("test single done");
  endtask
  task automatic t_space;
    logic [14:0] tab [6] = '{15'h6000, 15'h031F, 15'h5F40, 15'h1FFF, 15'h3FFF, 15'h5F3F};
    ind = 6'h10;
    for (int k = 0; k < 6; k++) begin
      isp[9:8] = tab[k][14:13];
      iad[64:52] = tab[k][12:0];
      if (k > 2) u_host.put(tab[k][14:13], tab[k][12:0], 32'h64);
      run;
      `CHK("refused", (k < 3), r)
      `CHK("error", 16'h0080, err)
      if (k > 2) `CHK("speed", 40'h64, spdo[39:0])
    end
    ind = 6'h00;
    $display("test space done");
  endtask
  task automatic t_interp;
    setp(3'h2, 2'h1, 8'h00, 32'h32, 32'h64, 32'hC8);
    lim = 36'h37;
    prev = err;
    run;
    `CHK("short", 40'h19, spdo[39:0])
    `CHK("long", 40'h32, spdo[79:40])
    `CHK("error", prev, err)
    `CHK("ramp", 36'h32, ramp)
    setp(3'h2, 2'h2, 8'h00, 32'h28, 32'h64, 32'hC8);
    run;
    `CHK("other", 40'h50, spdo[79:40])
    `CHK("ramp", 36'h28, ramp)
    ind = 6'h20;
    isp[11:10] = 2'h1;
    iad[77:65] = 13'h0010;
    u_host.put(2'h1, 13'h0010, 32'h2);
    run;
    `CHK("ref_word", 40'h14, spdo[39:0])
    ind = 6'h00;
    lim = 36'h5DC;
    setp(3'h2, 2'h0, 8'h00, 32'h1F4, 32'hBB8, 32'hFA0);
    run;
    `CHK("comb0", 40'h12C, spdo[39:0])
    `CHK("comb1", 40'h190, spdo[79:40])
    $display("test interp done");
  endtask
  task automatic t_units;
    setp(3'h2, 2'h1, 8'h04, 32'h64, 32'hFE, 32'h14);
    run;
    `CHK("to_mm", 40'h1FC, trvo[79:40])
    `CHK("mm_speed", 40'h32, spdo[39:0])
    setp(3'h2, 2'h1, 8'h04, 32'h64, 32'h1FC, 32'h28);
    iunit = 2'h1;
    run;
    `CHK("to_inch", 40'h14, trvo[39:0])
    `CHK("inch_speed", 40'h32, spdo[39:0])
    iunit = 2'h0;
    setp(3'h1, 2'h0, 8'h02, 32'h3, 32'h64, 32'h0);
    for (int k = 0; k < 2; k++) begin
      x10 = (k == 0);
      run;
      `CHK("degree", (k == 0) ? 36'h1E : 36'h3, ramp)
    end
    // Pulse interpolation, slot0 in mm through gear 4/1, slot1 negative with gear 3/1
    iunit = 2'h3;
    gnum = 64'h0000000000030004;
    gden = 64'h0000000000010001;
    setp(3'h2, 2'h1, 8'h0C, 32'h258, 32'h64, 32'hFFFFFF38);
    run;
    `CHK("gear_trv", 40'h190, trvo[39:0])
    `CHK("gear_ramp", 36'h1E, ramp)
    `CHK("gear_long", 40'h1E, spdo[39:0])
    `CHK("gear_other", 40'hF, spdo[79:40])
    `CHK("gear_dir", 4'h2, dir)
    {iunit, gnum, gden} = '0;
    $display("test units done");
  endtask
  initial begin
    rst_n = 1'b0;
    {x10, iunit, mode, unit, lim, spd, ind, isp, iad, trv, adone, gnum, gden} = '0;
    cnt = 3'h1;
    refc = 3'h1;
    ids = 20'h000C5;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_single;
    t_space;
    t_interp;
    t_units;
    results;
  end
  initial begin
    #2000000;
    n_mismatch++;
    results;
  end
endmodule
`default_nettype wire
